/* src/reo_pkg.sv */
package reo_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] REO_OFS_OFF_GATE = 8'h9f;
    localparam logic [7:0] REO_OFS_FORCE_FIRST = 8'ha0;
    localparam logic [7:0] REO_OFS_FORCE_SECOND = 8'ha1;

    // ----------------------------------------
    // off-gate field positions
    // ----------------------------------------
    localparam int REO_BIT_SHARED_OFF = 7;
    localparam int REO_BIT_SWITCH_B_ONE_OFF = 6;
    localparam int REO_BIT_SWITCH_A_ONE_OFF = 5;
    localparam int REO_BIT_TERM_OFF = 4;
    localparam logic [7:0] REO_OFF_GATE_RSVD_MASK = 8'h0f;

    // ----------------------------------------
    // first override field positions
    // ----------------------------------------
    localparam int REO_BIT_LDO2_ON = 7;
    localparam int REO_BIT_SWITCH_A_ONE_ON = 6;
    localparam int REO_BIT_BUCK_LSB = 0;
    localparam int REO_NUM_BUCK = 6;

    // ----------------------------------------
    // second override field positions
    // ----------------------------------------
    localparam int REO_BIT_GPO_LSB = 4;
    localparam int REO_NUM_GPO = 4;
    localparam int REO_BIT_TERM_ON = 3;
    localparam int REO_BIT_SHARED_ON = 2;
    localparam int REO_BIT_SWITCH_B_ONE_ON = 1;
    localparam int REO_BIT_LDO3_ON = 0;

    // ----------------------------------------
    // rail vector layout (index into enables)
    // ----------------------------------------
    localparam int REO_NUM_RAIL = 12;
    localparam int REO_RAIL_BUCK1 = 0;
    localparam int REO_RAIL_SWITCH_A_ONE = 6;
    localparam int REO_RAIL_LDO2 = 7;
    localparam int REO_RAIL_LDO3 = 8;
    localparam int REO_RAIL_SWITCH_B_ONE = 9;
    localparam int REO_RAIL_SHARED = 10;
    localparam int REO_RAIL_TERM = 11;

    // ----------------------------------------
    // register write request
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } reo_wr_t;

    // ----------------------------------------
    // factory configuration
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] off_gate_init;
        logic [7:0] force_first_init;
        logic [7:0] force_second_init;
        logic shared_is_switch;
        logic [3:0] gpo_host_ctrl;
    } reo_fuse_t;

endpackage

/* src/reo_rail_enable_override_regs.sv */
// Operation
// - off bit 6 clear forces switch_b_one off
// - off bit 5 clear forces switch_a_one off
// - off bit 4 clear forces termination regulator off
// - off bit 7 gates fuse-selected shared rail
// - A0h holds eight force-on bits in order
// - force-on zero leaves hardware request in control
// - force-on one enables rail unless gated off
// - A1h holds output levels and four force-ons
// - off-gate register lives at 9Fh
// - host-controlled outputs follow their level bits
// - termination force-on turns it on unless gated
`timescale 1ns/1ps
`default_nettype none

module reo_rail_enable_override_regs
    import reo_pkg::*;
#(
    parameter int NUM_RAIL = REO_NUM_RAIL,
    parameter int NUM_GPO = REO_NUM_GPO
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // register port
    input wire reo_wr_t i_reg_wr,
    input wire logic [7:0] i_reg_rd_addr,
    output logic [7:0] o_reg_rd_data,
    // factory configuration
    input wire reo_fuse_t i_fuse,
    // hardware requests (control pins already resolved, power-good tree)
    input wire logic [NUM_RAIL-1:0] i_rail_control_inputs,
    input wire logic [NUM_RAIL-1:0] i_rail_in_regulation,
    // rail enables
    output logic [NUM_RAIL-1:0] o_rail_enable,
    output logic o_ldo_one_enable,
    output logic o_switch_b_two_enable,
    // general outputs, open-drain style
    output logic [NUM_GPO-1:0] o_gpo_level,
    output logic [NUM_GPO-1:0] o_gpo_oe_n
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [NUM_RAIL-1:0] ctl_s1_q, ctl_s2_q, ctl_s3_q, ctl_q;

    always_ff @(posedge i_clk_sys) begin
        ctl_s1_q <= i_rail_control_inputs;
        ctl_s2_q <= ctl_s1_q;
        ctl_s3_q <= ctl_s2_q;
        if (i_reset) begin
            ctl_q <= '0;
        end else begin
            ctl_q <= ctl_s2_q & ctl_s3_q | ctl_q & (ctl_s2_q | ctl_s3_q);
        end
    end

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    logic [7:0] off_gate_q, force_first_q, force_second_q;
    logic loaded_q;
    wire hit_off = i_reg_wr.addr == REO_OFS_OFF_GATE;
    wire hit_first = i_reg_wr.addr == REO_OFS_FORCE_FIRST;
    wire hit_second = i_reg_wr.addr == REO_OFS_FORCE_SECOND;
    // a write in the fuse load cycle is dropped
    wire wr_ok = i_reg_wr.wr && loaded_q;
    wire wr_off = wr_ok && hit_off;
    wire wr_first = wr_ok && hit_first;
    wire wr_second = wr_ok && hit_second;
    // reserved bits kept at zero whatever is written
    wire [7:0] off_wr_data = i_reg_wr.data & ~REO_OFF_GATE_RSVD_MASK;
    wire [7:0] off_fuse_data = i_fuse.off_gate_init & ~REO_OFF_GATE_RSVD_MASK;

    // ----------------------------------------
    // fuse load marker
    // ----------------------------------------
    // fuse values taken on the first clock after reset release
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // off-gate register
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            off_gate_q <= 8'h00;
        end else if (!loaded_q) begin
            off_gate_q <= off_fuse_data;
        end else if (wr_off) begin
            off_gate_q <= off_wr_data;
        end
    end

    // ----------------------------------------
    // first override register
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            force_first_q <= 8'h00;
        end else if (!loaded_q) begin
            force_first_q <= i_fuse.force_first_init;
        end else if (wr_first) begin
            force_first_q <= i_reg_wr.data;
        end
    end

    // ----------------------------------------
    // second override register
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            force_second_q <= 8'h00;
        end else if (!loaded_q) begin
            force_second_q <= i_fuse.force_second_init;
        end else if (wr_second) begin
            force_second_q <= i_reg_wr.data;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire rd_sel_off = i_reg_rd_addr == REO_OFS_OFF_GATE;
    wire rd_sel_first = i_reg_rd_addr == REO_OFS_FORCE_FIRST;
    wire rd_sel_second = i_reg_rd_addr == REO_OFS_FORCE_SECOND;
    // unmapped offsets read as zero
    wire [7:0] rd_d = rd_sel_off ? off_gate_q :
                      rd_sel_first ? force_first_q :
                      rd_sel_second ? force_second_q : 8'h00;

    // ----------------------------------------
    // per-rail gate and force vectors
    // ----------------------------------------
    logic [NUM_RAIL-1:0] gate_vec, force_vec, req_vec, en_d;

    always_comb begin
        gate_vec = '1;
        gate_vec[REO_RAIL_SWITCH_B_ONE] = off_gate_q[REO_BIT_SWITCH_B_ONE_OFF];
        gate_vec[REO_RAIL_SWITCH_A_ONE] = off_gate_q[REO_BIT_SWITCH_A_ONE_OFF];
        gate_vec[REO_RAIL_TERM] = off_gate_q[REO_BIT_TERM_OFF];
        gate_vec[REO_RAIL_SHARED] = off_gate_q[REO_BIT_SHARED_OFF];
        force_vec = '0;
        force_vec[REO_RAIL_BUCK1 +: REO_NUM_BUCK] =
            force_first_q[REO_BIT_BUCK_LSB +: REO_NUM_BUCK];
        force_vec[REO_RAIL_SWITCH_A_ONE] = force_first_q[REO_BIT_SWITCH_A_ONE_ON];
        force_vec[REO_RAIL_LDO2] = force_first_q[REO_BIT_LDO2_ON];
        force_vec[REO_RAIL_LDO3] = force_second_q[REO_BIT_LDO3_ON];
        force_vec[REO_RAIL_SWITCH_B_ONE] = force_second_q[REO_BIT_SWITCH_B_ONE_ON];
        force_vec[REO_RAIL_SHARED] = force_second_q[REO_BIT_SHARED_ON];
        force_vec[REO_RAIL_TERM] = force_second_q[REO_BIT_TERM_ON];
    end

    // hardware request only matters while force-on is low
    assign req_vec = ctl_q | i_rail_in_regulation;
    // off gate wins over force-on
    assign en_d = loaded_q ? (gate_vec & (force_vec | req_vec)) : '0;

    // ----------------------------------------
    // general outputs
    // ----------------------------------------
    wire [NUM_GPO-1:0] lvl_bits = force_second_q[REO_BIT_GPO_LSB +: NUM_GPO];
    // host-controlled pins: low level pulls, high level releases
    wire [NUM_GPO-1:0] oe_n_d = ~(i_fuse.gpo_host_ctrl & ~lvl_bits);

    // ----------------------------------------
    // output flops: read data
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_reg_rd_data <= 8'h00;
        end else begin
            o_reg_rd_data <= rd_d;
        end
    end

    // ----------------------------------------
    // output flops: rail enables
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_rail_enable <= '0;
        end else begin
            o_rail_enable <= en_d;
        end
    end

    // ----------------------------------------
    // output flops: shared rail steering
    // ----------------------------------------
    // shared enable steered by fuse selection
    wire ldo_one_d = en_d[REO_RAIL_SHARED] & ~i_fuse.shared_is_switch;
    wire switch_b_two_d = en_d[REO_RAIL_SHARED] & i_fuse.shared_is_switch;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_ldo_one_enable <= 1'b0;
            o_switch_b_two_enable <= 1'b0;
        end else begin
            o_ldo_one_enable <= ldo_one_d;
            o_switch_b_two_enable <= switch_b_two_d;
        end
    end

    // ----------------------------------------
    // output flops: general outputs
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_gpo_level <= '0;
            o_gpo_oe_n <= '1;
        end else begin
            o_gpo_level <= lvl_bits & i_fuse.gpo_host_ctrl;
            o_gpo_oe_n <= oe_n_d;
        end
    end

endmodule

`default_nettype wire

/* test/rail_enable_override_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rail_enable_override_regs_test
    import reo_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reo_wr_t wr;
    logic [7:0] ra, rdat;
    reo_fuse_t fuse = '{8'hf0, 8'h80, 8'h01, 1'b1, 4'b0101};
    logic [11:0] ctl = '0, pg = '0, en;
    logic l1, s2;
    logic [3:0] lvl, oen;
    int errors = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    reo_host_model host (.i_clk_sys(clk), .o_reg_wr(wr), .o_rd_addr(ra), .i_rd_data(rdat));
    reo_rail_enable_override_regs dut (.i_clk_sys(clk), .i_reset(rst), .i_reg_wr(wr),
        .i_reg_rd_addr(ra), .o_reg_rd_data(rdat), .i_fuse(fuse), .i_rail_control_inputs(ctl),
        .i_rail_in_regulation(pg), .o_rail_enable(en), .o_ldo_one_enable(l1),
        .o_switch_b_two_enable(s2), .o_gpo_level(lvl), .o_gpo_oe_n(oen));
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.read(a, v);
        chk("readback", {4'h0, v}, {4'h0, e});
    endtask
    task automatic fuse_load;
        rd(8'h9f, 8'hf0);
        rd(8'ha0, 8'h80);
        rd(8'ha1, 8'h01);
    endtask
    task automatic gate_wins;
        @(posedge clk);
        pg <= '1;
        host.write(8'ha0, 8'hff);
        host.write(8'h9f, 8'h00);
        settle(2);
        chk("gated", en, 12'h1bf);
        chk("shared", {10'h0, l1, s2}, 12'h0);
        host.write(8'h9f, 8'hff);
        rd(8'h9f, 8'hf0);
        chk("ungated", en, 12'hfff);
    endtask
    task automatic force_only;
        @(posedge clk);
        pg <= '0;
        host.write(8'ha1, 8'h0f);
        settle(2);
        chk("forced", en, 12'hfff);
        chk("shared sw", {10'h0, l1, s2}, 12'h1);
        host.write(8'ha0, 8'h00);
        host.write(8'ha1, 8'h00);
        settle(2);
        chk("released", en, 12'h000);
        @(posedge clk);
        ctl <= 12'h008;
        settle(6);
        chk("pin request", en, 12'h008);
    endtask
    task automatic gpo_unmapped;
        host.write(8'ha1, 8'h10);
        settle(2);
        chk("gpo oe", {8'h0, oen}, 12'h00b);
        chk("gpo level", {8'h0, lvl}, 12'h001);
        host.write(8'h9e, 8'hff);
        rd(8'h9e, 8'h00);
        rd(8'ha1, 8'h10);
    endtask
    task automatic reset_reload;
        @(posedge clk);
        rst <= 1'b1;
        fuse <= '{8'hdf, 8'h41, 8'h06, 1'b0, 4'b0101};
        ctl <= '0;
        pg <= 12'h800;
        settle(2);
        chk("in reset", en, 12'h000);
        @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk("load edge", en, 12'h000);
        settle(1);
        chk("reloaded", en, 12'he01);
        chk("shared ldo", {10'h0, l1, s2}, 12'h002);
        chk("reload oe", {8'h0, oen}, 12'h00a);
        rd(8'h9f, 8'hd0);
    endtask
    task automatic close_out;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle(2);
        fuse_load();
        gate_wins();
        force_only();
        gpo_unmapped();
        reset_reload();
        close_out();
    end
endmodule
`default_nettype wire

/* test/reo_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module reo_host_model
    import reo_pkg::*;
(
    input wire logic i_clk_sys,
    output var reo_wr_t o_reg_wr,
    output logic [7:0] o_rd_addr,
    input wire logic [7:0] i_rd_data
);
    initial begin
        o_reg_wr = '0;
        o_rd_addr = 8'h00;
    end
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_reg_wr <= '{1'b1, a, (a == REO_OFS_OFF_GATE) ? (d & 8'hf0) : d};
        @(posedge i_clk_sys);
        o_reg_wr.wr <= 1'b0;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        o_rd_addr <= a;
        @(posedge i_clk_sys);
        #1 d = i_rd_data;
    endtask
endmodule
`default_nettype wire

/* test/reo_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module reo_regs_props
    import reo_pkg::*;
#(parameter int NUM_RAIL = 12, parameter int NUM_GPO = 4) (
    // clock, reset, register port
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire reo_wr_t i_reg_wr,
    input wire logic [7:0] i_reg_rd_addr,
    input wire logic [7:0] o_reg_rd_data,
    // configuration and requests
    input wire reo_fuse_t i_fuse,
    input wire logic [NUM_RAIL-1:0] i_rail_control_inputs,
    input wire logic [NUM_RAIL-1:0] i_rail_in_regulation,
    // enables and outputs
    input wire logic [NUM_RAIL-1:0] o_rail_enable,
    input wire logic o_ldo_one_enable,
    input wire logic o_switch_b_two_enable,
    input wire logic [NUM_GPO-1:0] o_gpo_level,
    input wire logic [NUM_GPO-1:0] o_gpo_oe_n
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    wire wg = i_reg_wr.wr && i_reg_wr.addr == REO_OFS_OFF_GATE;
    wire wf = i_reg_wr.wr && i_reg_wr.addr == REO_OFS_FORCE_FIRST;
    wire ws = i_reg_wr.wr && i_reg_wr.addr == REO_OFS_FORCE_SECOND;
    wire [7:0] wd = i_reg_wr.data;
    switch_b_one_gate_a: assert property ((wg && !wd[6]) ##1 !wg |=> !o_rail_enable[9])
        else $error("switch b one on while gated");
    switch_a_one_gate_a: assert property ((wg && !wd[5]) ##1 !wg |=> !o_rail_enable[6])
        else $error("switch a one on while gated");
    term_gate_a: assert property ((wg && !wd[4]) ##1 !wg |=> !o_rail_enable[11])
        else $error("termination on while gated");
    shared_gate_a: assert property (
        (wg && !wd[7]) ##1 !wg |=> !(o_ldo_one_enable || o_switch_b_two_enable))
        else $error("shared rail on while gated");
    rsvd_zero_a: assert property (i_reg_rd_addr == 8'h9f |=> o_reg_rd_data[3:0] == 4'h0)
        else $error("reserved gate bits not zero");
    buck_force_a: assert property ((wf && wd[0]) ##1 !wf |=> o_rail_enable[0])
        else $error("forced step-down one stays off");
    ldo3_force_a: assert property ((ws && wd[0]) ##1 !ws |=> o_rail_enable[8])
        else $error("forced ldo three stays off");
    gpo_low_a: assert property (
        (ws && !wd[4] && i_fuse.gpo_host_ctrl[0]) ##1 !ws |=> !o_gpo_oe_n[0])
        else $error("host output not driven low");
    gpo_free_a: assert property (!i_fuse.gpo_host_ctrl[1] |-> o_gpo_oe_n[1] && !o_gpo_level[1])
        else $error("non-host output driven");
endmodule
bind reo_rail_enable_override_regs reo_regs_props #(.NUM_RAIL(NUM_RAIL), .NUM_GPO(NUM_GPO))
    u_props (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd_addr(i_reg_rd_addr),
    .o_reg_rd_data(o_reg_rd_data),
    .i_fuse(i_fuse),
    .i_rail_control_inputs(i_rail_control_inputs),
    .i_rail_in_regulation(i_rail_in_regulation),
    .o_rail_enable(o_rail_enable),
    .o_ldo_one_enable(o_ldo_one_enable),
    .o_switch_b_two_enable(o_switch_b_two_enable),
    .o_gpo_level(o_gpo_level),
    .o_gpo_oe_n(o_gpo_oe_n)
);
`default_nettype wire
